// file: buffer_handshake_resync.sv
// Purpose: slave-side handshake resynchronisation for the exchange buffers
// Assumes: host writes the output buffer over the byte register port
// Notes:   slave user logic fills the input payload and low handshake bits
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps

module buffer_handshake_resync (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [resync_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [resync_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [resync_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic hs_wr_i,
    input wire logic [1:0] hs_bits_i,
    input wire logic in_wr_i,
    input wire logic [resync_pkg::IDX_W-1:0] in_idx_i,
    input wire logic [resync_pkg::DATA_W-1:0] in_data_i,
    input wire logic [resync_pkg::IDX_W-1:0] out_idx_i,
    output logic [resync_pkg::DATA_W-1:0] out_data_o,
    output logic [resync_pkg::DATA_W-1:0] host_ctrl_o,
    output logic [resync_pkg::DATA_W-1:0] host_len_o,
    output logic resync_active_o,
    output logic irq_o
);

    typedef struct packed {
        resync_pkg::fsm_t fsm;
        logic [resync_pkg::DATA_W-1:0] host_ctrl;
        logic [resync_pkg::DATA_W-1:0] host_cons;
        logic [resync_pkg::DATA_W-1:0] host_len;
        logic [resync_pkg::DATA_W-1:0] slave_ctrl;
        logic [resync_pkg::DATA_W-1:0] slave_cons;
        logic [resync_pkg::EV_W-1:0] status;
        logic [resync_pkg::EV_W-1:0] mask;
        logic [resync_pkg::DATA_W-1:0] resync_cnt;
        resync_pkg::rsel_t rsel;
        logic [resync_pkg::DATA_W-1:0] rbyte;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic [1:0] bus_region;
    logic [resync_pkg::IDX_W-1:0] bus_idx;
    logic host_payload;
    logic slave_payload;
    logic host_mem_wr;
    logic [resync_pkg::DATA_W-1:0] host_agreed;
    logic [resync_pkg::DATA_W-1:0] host_mem_bus_data;
    logic [resync_pkg::DATA_W-1:0] slave_mem_bus_data;
    logic [resync_pkg::EV_W-1:0] ev_set;
    logic [resync_pkg::EV_W-1:0] ev_clr;
    logic slave_in_wr;

    // address split: upper bits pick a buffer, lower bits the byte
    assign bus_region = reg_addr_i[resync_pkg::ADDR_W-1:resync_pkg::IDX_W];
    assign bus_idx = reg_addr_i[resync_pkg::IDX_W-1:0];
    assign host_payload = (bus_idx != resync_pkg::IDX_CTRL) &&
                          (bus_idx != resync_pkg::IDX_CONS);
    assign slave_payload = (in_idx_i != resync_pkg::IDX_CTRL) &&
                           (in_idx_i != resync_pkg::IDX_CONS);
    assign host_mem_wr = reg_wr_i && (bus_region == resync_pkg::REGION_HOST) && host_payload;
    // handshake bytes are owned by the resync logic, never by the payload path
    assign slave_in_wr = in_wr_i && slave_payload;

    // host payload bytes 1..30; byte 0 and 31 live in dedicated registers
    byte_buffer_mem #(
        .DEPTH(resync_pkg::BUF_DEPTH),
        .IDX_W(resync_pkg::IDX_W),
        .DATA_W(resync_pkg::DATA_W)
    ) u_host_mem (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(host_mem_wr),
        .wr_idx_i(bus_idx),
        .wr_data_i(reg_wdata_i),
        .rd_a_idx_i(bus_idx),
        .rd_a_data_o(host_mem_bus_data),
        .rd_b_idx_i(out_idx_i),
        .rd_b_data_o(out_data_o)
    );

    // slave payload bytes, filled by the gateway user logic
    byte_buffer_mem #(
        .DEPTH(resync_pkg::BUF_DEPTH),
        .IDX_W(resync_pkg::IDX_W),
        .DATA_W(resync_pkg::DATA_W)
    ) u_slave_mem (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(slave_in_wr),
        .wr_idx_i(in_idx_i),
        .wr_data_i(in_data_i),
        .rd_a_idx_i(bus_idx),
        .rd_a_data_o(slave_mem_bus_data),
        .rd_b_idx_i(in_idx_i),
        .rd_b_data_o()
    );

    // host control byte only counts once its mirror matches
    consistency_check #(
        .DATA_W(resync_pkg::DATA_W)
    ) u_host_check (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .ctrl_i(st_reg.host_ctrl),
        .cons_i(st_reg.host_cons),
        .agreed_o(host_agreed)
    );

    // main next-state: bus writes, resync machine, events, read capture
    always_comb begin
        st_next = st_reg;
        ev_set = '0;
        ev_clr = '0;

        // host side writes to the output buffer handshake bytes and length byte
        if (reg_wr_i && (bus_region == resync_pkg::REGION_HOST)) begin
            if (bus_idx == resync_pkg::IDX_CTRL) begin
                st_next.host_ctrl = reg_wdata_i;
            end else if (bus_idx == resync_pkg::IDX_CONS) begin
                st_next.host_cons = reg_wdata_i;
            end else if (bus_idx == resync_pkg::IDX_LEN) begin
                st_next.host_len = reg_wdata_i;
            end
        end

        // interrupt mask and write-one-to-clear status
        if (reg_wr_i && (bus_region == resync_pkg::REGION_MISC)) begin
            if (bus_idx == resync_pkg::MISC_STATUS) begin
                ev_clr = reg_wdata_i[resync_pkg::EV_W-1:0];
            end else if (bus_idx == resync_pkg::MISC_MASK) begin
                st_next.mask = reg_wdata_i[resync_pkg::EV_W-1:0];
            end
        end

        // resync machine, both slave bytes always written together
        case (st_reg.fsm)
            resync_pkg::ST_IDLE: begin
                if (host_agreed[resync_pkg::BIT_RESYNC]) begin
                    st_next.fsm = resync_pkg::ST_ACK;
                    // bit 2 up, bits 1 and 0 forced low whatever they held
                    st_next.slave_ctrl = resync_pkg::CTRL_ACK;
                    st_next.slave_cons = resync_pkg::CTRL_ACK;
                    st_next.resync_cnt = st_reg.resync_cnt + 8'h01;
                    ev_set[resync_pkg::EV_REQ] = 1'b1;
                end else if (hs_wr_i) begin
                    // normal handshaking only touches bits 1 and 0
                    st_next.slave_ctrl = (st_reg.slave_ctrl & ~resync_pkg::HS_LOW_MASK) |
                                         {6'h00, hs_bits_i};
                    st_next.slave_cons = (st_reg.slave_cons & ~resync_pkg::HS_LOW_MASK) |
                                         {6'h00, hs_bits_i};
                end
            end
            resync_pkg::ST_ACK: begin
                // bit 2 is held as a level until the host drops its own
                if (!host_agreed[resync_pkg::BIT_RESYNC]) begin
                    st_next.fsm = resync_pkg::ST_IDLE;
                    st_next.slave_ctrl = resync_pkg::CTRL_RESET;
                    st_next.slave_cons = resync_pkg::CTRL_RESET;
                    ev_set[resync_pkg::EV_DONE] = 1'b1;
                end
            end
            default: begin
                st_next.fsm = resync_pkg::ST_IDLE;
                st_next.slave_ctrl = resync_pkg::CTRL_RESET;
                st_next.slave_cons = resync_pkg::CTRL_RESET;
            end
        endcase

        // a new event in the clearing cycle survives the clear
        st_next.status = (st_reg.status & ~ev_clr) | ev_set;

        // read capture: data returns in the cycle after the strobe
        st_next.rsel = resync_pkg::RSEL_REG;
        st_next.rbyte = resync_pkg::BYTE_ZERO;
        if (reg_rd_i) begin
            case (bus_region)
                resync_pkg::REGION_HOST: begin
                    if (bus_idx == resync_pkg::IDX_CTRL) begin
                        st_next.rbyte = st_reg.host_ctrl;
                    end else if (bus_idx == resync_pkg::IDX_CONS) begin
                        st_next.rbyte = st_reg.host_cons;
                    end else if (bus_idx == resync_pkg::IDX_LEN) begin
                        st_next.rbyte = st_reg.host_len;
                    end else begin
                        st_next.rsel = resync_pkg::RSEL_HOST_MEM;
                    end
                end
                resync_pkg::REGION_SLAVE: begin
                    if (bus_idx == resync_pkg::IDX_CTRL) begin
                        st_next.rbyte = st_reg.slave_ctrl;
                    end else if (bus_idx == resync_pkg::IDX_CONS) begin
                        st_next.rbyte = st_reg.slave_cons;
                    end else begin
                        st_next.rsel = resync_pkg::RSEL_SLAVE_MEM;
                    end
                end
                resync_pkg::REGION_MISC: begin
                    if (bus_idx == resync_pkg::MISC_STATUS) begin
                        st_next.rbyte = {6'h00, st_reg.status};
                    end else if (bus_idx == resync_pkg::MISC_MASK) begin
                        st_next.rbyte = {6'h00, st_reg.mask};
                    end else if (bus_idx == resync_pkg::MISC_COUNT) begin
                        st_next.rbyte = st_reg.resync_cnt;
                    end else if (bus_idx == resync_pkg::MISC_STATE) begin
                        st_next.rbyte = {7'h00, st_reg.fsm};
                    end
                end
                default: begin
                    // unmapped space reads zero
                    st_next.rbyte = resync_pkg::BYTE_ZERO;
                end
            endcase
        end
    end

    // slave bytes come up idle with the online bit set
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
            st_reg.slave_ctrl <= resync_pkg::CTRL_RESET;
            st_reg.slave_cons <= resync_pkg::CTRL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // read mux selects between flopped sources only
    always_comb begin
        case (st_reg.rsel)
            resync_pkg::RSEL_HOST_MEM: reg_rdata_o = host_mem_bus_data;
            resync_pkg::RSEL_SLAVE_MEM: reg_rdata_o = slave_mem_bus_data;
            default: reg_rdata_o = st_reg.rbyte;
        endcase
    end

    assign host_ctrl_o = host_agreed;
    assign host_len_o = st_reg.host_len;
    assign resync_active_o = (st_reg.fsm == resync_pkg::ST_ACK);
    assign irq_o = |(st_reg.status & st_reg.mask);

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // agreed request in idle raises the ack in both slave bytes
    a_req_ack_both: assert property (
        (st_reg.fsm == resync_pkg::ST_IDLE) && host_agreed[resync_pkg::BIT_RESYNC]
        |=> st_reg.slave_ctrl[resync_pkg::BIT_RESYNC] && st_reg.slave_cons[resync_pkg::BIT_RESYNC])
        else $error("resync request not acknowledged in both slave bytes");

    // low handshake bits stay zero for the whole ack phase
    a_ack_low_zero: assert property (
        st_reg.slave_ctrl[resync_pkg::BIT_RESYNC]
        |-> (st_reg.slave_ctrl[resync_pkg::BIT_HS1:resync_pkg::BIT_HS0] == 2'h0) &&
            (st_reg.slave_cons[resync_pkg::BIT_HS1:resync_pkg::BIT_HS0] == 2'h0))
        else $error("handshake bits 1 or 0 set during resync");

    // host withdrawal is answered by clearing bit 2 next cycle
    a_release_clear: assert property (
        resync_active_o && !host_agreed[resync_pkg::BIT_RESYNC]
        |=> !st_reg.slave_ctrl[resync_pkg::BIT_RESYNC] &&
            !st_reg.slave_cons[resync_pkg::BIT_RESYNC])
        else $error("slave bit 2 not cleared after host release");

    // completion leaves the handshake bits zero and the machine idle
    a_done_idle: assert property (
        $fell(st_reg.slave_ctrl[resync_pkg::BIT_RESYNC])
        |-> (st_reg.slave_ctrl == resync_pkg::CTRL_RESET) && !resync_active_o)
        else $error("resync completion not idle with zero handshake");

    // bit 2 is held while the host keeps requesting
    a_bit2_level: assert property (
        resync_active_o && host_agreed[resync_pkg::BIT_RESYNC]
        |=> st_reg.slave_ctrl[resync_pkg::BIT_RESYNC] [*1] ##0 resync_active_o)
        else $error("slave bit 2 dropped while request stands");

    // mirror byte always equals the control byte
    a_mirror_equal: assert property (
        st_reg.slave_ctrl == st_reg.slave_cons)
        else $error("slave consistency byte differs from control byte");

    // ack phase shows the exact control value
    a_ack_value: assert property (
        resync_active_o |-> (st_reg.slave_ctrl == resync_pkg::CTRL_ACK))
        else $error("slave control byte not 84 hex during resync");

    // agreed value moves only from a matching pair
    a_agree_only: assert property (
        !$stable(host_agreed) |-> $past(st_reg.host_ctrl == st_reg.host_cons))
        else $error("host control acted on while bytes disagree");

    // a torn write of the control byte alone never starts a resync
    a_torn_ignored: assert property (
        (st_reg.fsm == resync_pkg::ST_IDLE) && !host_agreed[resync_pkg::BIT_RESYNC] &&
        (st_reg.host_ctrl != st_reg.host_cons) [*2]
        |=> !resync_active_o)
        else $error("resync started from mismatched host bytes");

    // a started resync always leaves its request event behind
    a_req_event: assert property (
        $rose(resync_active_o) |-> st_reg.status[resync_pkg::EV_REQ])
        else $error("resync start did not set the request event");

    // a finished resync always leaves its done event behind
    a_done_event: assert property (
        $fell(resync_active_o) |-> st_reg.status[resync_pkg::EV_DONE])
        else $error("resync completion did not set the done event");

    // outside resync the user bits reach both slave bytes
    a_hs_update: assert property (
        (st_reg.fsm == resync_pkg::ST_IDLE) && !host_agreed[resync_pkg::BIT_RESYNC] && hs_wr_i
        |=> (st_reg.slave_ctrl[resync_pkg::BIT_HS1:resync_pkg::BIT_HS0] == $past(hs_bits_i)) &&
            (st_reg.slave_cons[resync_pkg::BIT_HS1:resync_pkg::BIT_HS0] == $past(hs_bits_i)))
        else $error("handshake bits not loaded into both slave bytes");

    // each accepted request bumps the resync counter by one
    a_count_step: assert property (
        (st_reg.fsm == resync_pkg::ST_IDLE) && host_agreed[resync_pkg::BIT_RESYNC]
        |=> st_reg.resync_cnt == $past(st_reg.resync_cnt) + 8'h01)
        else $error("resync counter did not step on a request");

    // the online bit never drops in either slave byte
    a_online_bit: assert property (
        st_reg.slave_ctrl[resync_pkg::BIT_ONLINE] && st_reg.slave_cons[resync_pkg::BIT_ONLINE])
        else $error("slave online bit cleared");

    // without an agreed request the machine never leaves idle
    a_stay_idle: assert property (
        (st_reg.fsm == resync_pkg::ST_IDLE) && !host_agreed[resync_pkg::BIT_RESYNC]
        |=> !resync_active_o)
        else $error("resync started without an agreed request");

endmodule

// file: resync_pkg.sv
// Purpose: shared constants and types for the buffer handshake resync block
// Assumes: byte-wide register port, 7-bit byte address
// Notes:   both exchange buffers are 32 bytes with handshake bytes at 0 and 31
package resync_pkg;

    // buffer geometry
    localparam int BUF_DEPTH = 32;
    localparam int IDX_W = 5;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;

    // byte positions inside a buffer
    localparam logic [IDX_W-1:0] IDX_CTRL = 5'h00;
    localparam logic [IDX_W-1:0] IDX_ZERO = 5'h01;
    localparam logic [IDX_W-1:0] IDX_LEN = 5'h02;
    localparam logic [IDX_W-1:0] IDX_CONS = 5'h1F;

    // register port map: two buffers, then interrupt and state registers
    localparam logic [1:0] REGION_HOST = 2'h0;
    localparam logic [1:0] REGION_SLAVE = 2'h1;
    localparam logic [1:0] REGION_MISC = 2'h2;
    localparam logic [IDX_W-1:0] MISC_STATUS = 5'h00;
    localparam logic [IDX_W-1:0] MISC_MASK = 5'h01;
    localparam logic [IDX_W-1:0] MISC_COUNT = 5'h02;
    localparam logic [IDX_W-1:0] MISC_STATE = 5'h03;

    // handshake bit positions
    localparam int BIT_RESYNC = 2;
    localparam int BIT_HS1 = 1;
    localparam int BIT_HS0 = 0;
    localparam int BIT_ONLINE = 7;

    // control byte values
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h80;
    localparam logic [DATA_W-1:0] CTRL_ACK = 8'h84;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] HS_LOW_MASK = 8'h03;

    // interrupt status bits
    localparam int EV_W = 2;
    localparam int EV_REQ = 0;
    localparam int EV_DONE = 1;

    typedef enum logic [0:0] {
        ST_IDLE = 1'h0,
        ST_ACK = 1'h1
    } fsm_t;

    typedef enum logic [1:0] {
        RSEL_REG = 2'h0,
        RSEL_HOST_MEM = 2'h1,
        RSEL_SLAVE_MEM = 2'h2
    } rsel_t;

endpackage

// file: byte_buffer_mem.sv
// Purpose: small exchange buffer memory, one write port, two read ports
// Assumes: read data registered, one cycle after the read address
// Notes:   reset clears contents so unused payload bytes read as zero
`timescale 1ns/100ps
module byte_buffer_mem #(
    parameter int DEPTH = 32,
    parameter int IDX_W = 5,
    parameter int DATA_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic wr_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic [IDX_W-1:0] rd_a_idx_i,
    output logic [DATA_W-1:0] rd_a_data_o,
    input wire logic [IDX_W-1:0] rd_b_idx_i,
    output logic [DATA_W-1:0] rd_b_data_o
);

    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] mem;
        logic [DATA_W-1:0] rd_a;
        logic [DATA_W-1:0] rd_b;
    } mem_state_t;

    mem_state_t st_reg;
    mem_state_t st_next;

    // two read ports so bus reads never starve the user side
    always_comb begin
        st_next = st_reg;
        st_next.rd_a = st_reg.mem[rd_a_idx_i];
        st_next.rd_b = st_reg.mem[rd_b_idx_i];
        if (wr_i) begin
            st_next.mem[wr_idx_i] = wr_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_a_data_o = st_reg.rd_a;
    assign rd_b_data_o = st_reg.rd_b;

endmodule

// file: consistency_check.sv
// Purpose: passes a control byte on only once its mirror byte agrees
// Assumes: writer updates the control byte first, the mirror second
// Notes:   output holds its last agreed value while the two differ
`timescale 1ns/100ps
module consistency_check #(
    parameter int DATA_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [DATA_W-1:0] ctrl_i,
    input wire logic [DATA_W-1:0] cons_i,
    output logic [DATA_W-1:0] agreed_o
);

    typedef struct packed {
        logic [DATA_W-1:0] agreed;
    } chk_state_t;

    chk_state_t st_reg;
    chk_state_t st_next;

    // half-written pairs are ignored, avoiding action on torn updates
    always_comb begin
        st_next = st_reg;
        if (ctrl_i == cons_i) begin
            st_next.agreed = ctrl_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign agreed_o = st_reg.agreed;

endmodule

// file: host_master_model.sv
// Purpose: host master model driving the byte register port of the resync block
// Assumes: read data stands only in the cycle after the read strobe
// Notes:   address and data are inverted when released so stale values never match
`timescale 1ns/100ps
module host_master_model (
    input wire logic ref_clk_i,
    input wire logic [resync_pkg::DATA_W-1:0] rdata_i,
    output logic [resync_pkg::ADDR_W-1:0] addr_o,
    output logic [resync_pkg::DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // idle bus at time zero
    initial begin
        addr_o = 7'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // one-cycle write, then release with inverted lines
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge ref_clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    // one-cycle read, data taken mid-cycle to stay clear of the flop update
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge ref_clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(negedge ref_clk_i);
        d = rdata_i;
    endtask

    // start: control byte first, mirror second, bit 2 driven to one
    task automatic resync_request();
        wr(7'h00, resync_pkg::CTRL_ACK);
        wr(7'h1F, resync_pkg::CTRL_ACK);
    endtask

    // release once the slave control byte shows the acknowledge, or after 8 reads without it
    task automatic resync_release();
        logic [7:0] d;
        int n;
        n = 0;
        d = 8'h00;
        while (d[resync_pkg::BIT_RESYNC] !== 1'b1 && n < 8) begin
            rd(7'h20, d);
            n++;
        end
        wr(7'h00, resync_pkg::CTRL_RESET);
        wr(7'h1F, resync_pkg::CTRL_RESET);
    endtask

    // packet header: byte 1 stays zero, length in byte 2
    task automatic load_packet(input logic [7:0] len);
        wr(7'h01, resync_pkg::BYTE_ZERO);
        wr(7'h02, len);
    endtask
endmodule

// file: buffer_handshake_resync_bench.sv
// Purpose: self-checking bench for the buffer handshake resync block
// Assumes: host master model owns the register port
// Notes:   read results are checked against a queue of expected bytes
`timescale 1ns/100ps
module buffer_handshake_resync_bench;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic hs_wr = 1'b0;
    logic [1:0] hs_bits = 2'h0;
    logic in_wr = 1'b0;
    logic [4:0] in_idx = 5'h00;
    logic [7:0] in_data = 8'h00;
    logic [4:0] out_idx = 5'h00;
    logic [7:0] out_data;
    logic [7:0] host_ctrl;
    logic [7:0] host_len;
    logic resync_active;
    logic irq;
    logic rd_pend = 1'b0;
    logic [31:0] seed = 32'h00007619;
    logic [7:0] rnd;
    logic [1:0] rnd_hs;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;

    buffer_handshake_resync i_dut (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .hs_wr_i(hs_wr), .hs_bits_i(hs_bits), .in_wr_i(in_wr),
        .in_idx_i(in_idx), .in_data_i(in_data), .out_idx_i(out_idx), .out_data_o(out_data),
        .host_ctrl_o(host_ctrl), .host_len_o(host_len), .resync_active_o(resync_active),
        .irq_o(irq)
    );

    host_master_model i_host (
        .ref_clk_i(ref_clk_i), .rdata_i(reg_rdata), .addr_o(reg_addr),
        .wdata_o(reg_wdata), .wr_o(reg_wr), .rd_o(reg_rd)
    );

    always #20 ref_clk_i = ~ref_clk_i;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // note the expected byte, then let the host read it
    task automatic expect_rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        exp_q.push_back(e);
        i_host.rd(a, d);
    endtask

    // bounded wait on the acknowledge phase level
    task automatic wait_active(input logic v);
        int n;
        n = 0;
        while (resync_active !== v && n < 8) begin
            @(negedge ref_clk_i);
            n++;
        end
        check("resync_active", {7'h00, resync_active}, {7'h00, v});
    endtask

    task automatic hs_pulse(input logic [1:0] b);
        @(posedge ref_clk_i);
        hs_bits <= b;
        hs_wr <= 1'b1;
        @(posedge ref_clk_i);
        hs_wr <= 1'b0;
    endtask

    task automatic slave_wr(input logic [4:0] i, input logic [7:0] d);
        @(posedge ref_clk_i);
        in_idx <= i;
        in_data <= d;
        in_wr <= 1'b1;
        @(posedge ref_clk_i);
        in_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge ref_clk_i) begin
        rd_pend <= reg_rd;
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            report_and_stop();
        end
    end

    always @(negedge ref_clk_i) begin
        if (rd_pend) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("mismatch read_data expected none seen %h", reg_rdata);
            end else begin
                check("read_data", reg_rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        // reset values, and an unmapped address reading zero
        expect_rd(7'h20, resync_pkg::CTRL_RESET);
        expect_rd(7'h3F, resync_pkg::CTRL_RESET);
        expect_rd(7'h40, 8'h00);
        expect_rd(7'h41, 8'h00);
        expect_rd(7'h7F, 8'h00);
        // packet header and host payload pass-through
        seed = lfsr_next(seed);
        rnd = seed[7:0];
        i_host.load_packet(rnd);
        repeat (2) @(negedge ref_clk_i);
        check("host_len", host_len, rnd);
        seed = lfsr_next(seed);
        i_host.wr(7'h05, seed[7:0]);
        out_idx <= 5'h05;
        repeat (3) @(negedge ref_clk_i);
        check("out_data", out_data, seed[7:0]);
        // slave payload, and handshake bytes not reachable as payload
        seed = lfsr_next(seed);
        slave_wr(5'h07, seed[7:0]);
        expect_rd(7'h27, seed[7:0]);
        slave_wr(5'h00, 8'hFF);
        expect_rd(7'h20, resync_pkg::CTRL_RESET);
        i_host.wr(7'h25, 8'h5A);
        expect_rd(7'h25, 8'h00);
        // nonzero handshake bits mirrored in both slave bytes
        rnd_hs = {seed[9], 1'b1};
        hs_pulse(rnd_hs);
        expect_rd(7'h20, {6'h20, rnd_hs});
        expect_rd(7'h3F, {6'h20, rnd_hs});
        // two full resync rounds; mask stays off in the first
        for (int k = 1; k <= 2; k++) begin
            i_host.wr(7'h00, resync_pkg::CTRL_ACK);
            repeat (4) @(negedge ref_clk_i);
            check("resync_active", {7'h00, resync_active}, 8'h00);
            check("host_ctrl", host_ctrl, (k == 1) ? 8'h00 : 8'h80);
            i_host.wr(7'h1F, resync_pkg::CTRL_ACK);
            wait_active(1'b1);
            expect_rd(7'h20, resync_pkg::CTRL_ACK);
            expect_rd(7'h3F, resync_pkg::CTRL_ACK);
            hs_pulse(2'h3);
            expect_rd(7'h20, resync_pkg::CTRL_ACK);
            expect_rd(7'h40, 8'h01);
            check("irq", {7'h00, irq}, (k == 2) ? 8'h01 : 8'h00);
            i_host.wr(7'h40, 8'h01);
            expect_rd(7'h40, 8'h00);
            check("irq", {7'h00, irq}, 8'h00);
            exp_q.push_back(resync_pkg::CTRL_ACK);
            i_host.resync_release();
            wait_active(1'b0);
            expect_rd(7'h20, resync_pkg::CTRL_RESET);
            expect_rd(7'h3F, resync_pkg::CTRL_RESET);
            expect_rd(7'h40, 8'h02);
            check("irq", {7'h00, irq}, (k == 2) ? 8'h01 : 8'h00);
            expect_rd(7'h42, k[7:0]);
            expect_rd(7'h43, 8'h00);
            i_host.wr(7'h40, 8'h02);
            i_host.wr(7'h41, 8'h03);
        end
        repeat (4) @(negedge ref_clk_i);
        check("irq", {7'h00, irq}, 8'h00);
        report_and_stop();
    end
endmodule
